// [logic/sfsbc_core.v]
`timescale 1ns/100ps
`include "sfsbc_defs.vh"
module sfsbc_core #(
  parameter NV_OP_CYCLES = `SFSBC_NV_OP_CYC
) (
  input  wire        sys_clk_i,
  input  wire        rst_b_i,
  input  wire        pwr_on_b_i,
  input  wire        cs_b_i,
  input  wire        sck_i,
  input  wire [3:0]  io_i,
  output reg  [3:0]  io_o,
  output reg  [3:0]  io_oe_o,
  input  wire        quad_enable_i,
  input  wire [7:0]  ecc_status_i,
  input  wire [7:0]  array_data_i,
  input  wire        erase_fail_i,
  input  wire        prog_fail_i,
  output reg  [31:0] ecc_addr_o,
  output reg  [31:0] array_addr_o,
  output reg  [31:0] boot_stream_config_o,
  output reg  [7:0]  learning_pattern_o,
  output reg  [7:0]  pattern_nonvolatile_reg_o,
  output reg         write_enable_latch_o,
  output reg         write_in_progress_o,
  output reg         erase_err_o,
  output reg         prog_err_o,
  output reg         boot_armed_o
);
  localparam ST_IDLE  = 7'h01;
  localparam ST_CMD   = 7'h02;
  localparam ST_ADDR  = 7'h04;
  localparam ST_DUMMY = 7'h08;
  localparam ST_OUT   = 7'h10;
  localparam ST_IN    = 7'h20;
  localparam ST_BOOT  = 7'h40;
  localparam SEL_ECC  = 2'h0;
  localparam SEL_CFG  = 2'h1;
  localparam SEL_PAT  = 2'h2;

  wire [2:0]  pins_s;
  wire        cs_s;
  wire        sck_s;
  wire        si_s;
  reg         cs_d;
  reg         sck_d;
  reg  [6:0]  state;
  reg  [7:0]  cmd_reg;
  reg  [5:0]  bit_cnt;
  reg  [31:0] in_shift;
  reg  [7:0]  wait_cnt;
  reg  [3:0]  rep;
  reg  [1:0]  out_sel;
  reg  [7:0]  out_byte;
  reg  [3:0]  out_left;
  reg         cur_quad;
  reg         boot_byte_done;
  reg         init_done;
  reg         op_active;
  reg         op_is_cfg;
  reg  [15:0] op_cnt;
  reg  [31:0] pend_cfg;
  reg  [7:0]  pend_pat;
  reg         do_load;
  reg         do_shift;
  reg  [7:0]  load_byte;
  reg  [7:0]  next_cmd;
  wire        sck_rise;
  wire        sck_fall;
  wire        cs_fall;
  wire        cs_rise;
  wire        boot_start;
  wire        op_done;
  wire        cfg_commit;
  wire        pat_commit;
  wire        wip_now;
  wire        load_quad;

  function [31:0] byte_swap;
    input [31:0] v;
    begin
      byte_swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
    end
  endfunction

  function [7:0] cfg_byte;
    input [31:0] v;
    input [1:0]  idx;
    begin
      if (idx == 2'h0) cfg_byte = v[7:0];
      else if (idx == 2'h1) cfg_byte = v[15:8];
      else if (idx == 2'h2) cfg_byte = v[23:16];
      else cfg_byte = v[31:24];
    end
  endfunction

  function [5:0] data_len;
    input [7:0] c;
    begin
      if (c == `SFSBC_CMD_CFGWR) data_len = 6'h20;
      else if (c == `SFSBC_CMD_PATNV || c == `SFSBC_CMD_PATV) data_len = 6'h08;
      else data_len = 6'h00;
    end
  endfunction

  sfsbc_sync #(
    .WIDTH(3),
    .RST_VAL(3'h4)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({cs_b_i, sck_i, io_i[0]}),
    .sync_o    (pins_s)
  );

  assign cs_s       = pins_s[2];
  assign sck_s      = pins_s[1];
  assign si_s       = pins_s[0];
  assign sck_rise   = sck_s & ~sck_d & ~cs_s;
  assign sck_fall   = ~sck_s & sck_d & ~cs_s;
  assign cs_fall    = ~cs_s & cs_d;
  assign cs_rise    = cs_s & ~cs_d;
  assign boot_start = cs_fall & boot_armed_o & init_done; // R06
  assign op_done    = op_active && (op_cnt == 16'h0001);
  assign cfg_commit = op_done & op_is_cfg & ~erase_fail_i & ~prog_fail_i;
  assign pat_commit = op_done & ~op_is_cfg & ~prog_fail_i;
  assign wip_now    = op_active | erase_err_o | prog_err_o;
  assign load_quad  = boot_start ? quad_enable_i : cur_quad;

  // output step and byte selection
  always @* begin
    do_load   = 1'b0;
    do_shift  = 1'b0;
    load_byte = learning_pattern_o; // R22
    next_cmd  = {cmd_reg[6:0], si_s};
    if (boot_start) begin
      do_load = (boot_stream_config_o[`SFSBC_DLY_MSB:`SFSBC_DLY_LSB] == 8'h00); // R07
    end else if (sck_fall) begin
      if ((state == ST_DUMMY || state == ST_BOOT) && wait_cnt != 8'h00) begin
        do_load = (wait_cnt == 8'h01); // R07
      end else if (state == ST_OUT || state == ST_BOOT) begin
        if (out_left > 4'h1) do_shift = 1'b1;
        else do_load = 1'b1;
      end
    end
    if (state == ST_BOOT || boot_start) begin
      load_byte = array_data_i;
    end else if (out_sel == SEL_ECC) begin
      load_byte = ecc_status_i;
    end else if (out_sel == SEL_CFG) begin
      load_byte = cfg_byte(boot_stream_config_o, rep[1:0]); // R14
    end
  end

  // non-volatile storage, kept across hardware reset, cleared only at power on
  always @(posedge sys_clk_i or negedge pwr_on_b_i) begin
    if (!pwr_on_b_i) begin
      boot_stream_config_o      <= `SFSBC_BOOT_CFG_RST; // R08
      pattern_nonvolatile_reg_o <= `SFSBC_PATTERN_RST;
    end else begin
      if (cfg_commit) boot_stream_config_o <= pend_cfg; // R26
      if (pat_commit) pattern_nonvolatile_reg_o <= pend_pat;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_d                 <= 1'b1;
      sck_d                <= 1'b0;
      state                <= ST_IDLE;
      cmd_reg              <= 8'h00;
      bit_cnt              <= 6'h00;
      in_shift             <= 32'h0000_0000;
      wait_cnt             <= 8'h00;
      rep                  <= 4'h0;
      out_sel              <= SEL_ECC;
      out_byte             <= 8'h00;
      out_left             <= 4'h0;
      cur_quad             <= 1'b0;
      boot_byte_done       <= 1'b0;
      init_done            <= 1'b0;
      op_active            <= 1'b0;
      op_is_cfg            <= 1'b0;
      op_cnt               <= 16'h0000;
      pend_cfg             <= 32'h0000_0000;
      pend_pat             <= 8'h00;
      io_o                 <= 4'h0;
      io_oe_o              <= 4'h0;
      ecc_addr_o           <= 32'h0000_0000;
      array_addr_o         <= 32'h0000_0000;
      learning_pattern_o   <= 8'h00;
      write_enable_latch_o <= 1'b0;
      write_in_progress_o  <= 1'b0;
      erase_err_o          <= 1'b0;
      prog_err_o           <= 1'b0;
      boot_armed_o         <= 1'b0;
    end else begin
      cs_d                <= cs_s;
      sck_d               <= sck_s;
      write_in_progress_o <= wip_now; // R02
      if (!init_done) begin
        init_done          <= 1'b1;
        learning_pattern_o <= pattern_nonvolatile_reg_o; // R24
        boot_armed_o       <= boot_stream_config_o[`SFSBC_BEN_BIT]; // R26
        array_addr_o       <= {boot_stream_config_o[`SFSBC_SA_MSB:`SFSBC_SA_LSB], 9'h000}; // R08
      end
      if (op_active) op_cnt <= op_cnt - 16'h0001;
      if (cs_fall) begin
        bit_cnt        <= 6'h00;
        out_left       <= 4'h0;
        boot_byte_done <= 1'b0;
        cur_quad       <= boot_start & quad_enable_i; // R12
        if (boot_start) begin
          state    <= ST_BOOT;
          wait_cnt <= boot_stream_config_o[`SFSBC_DLY_MSB:`SFSBC_DLY_LSB]; // R07
        end else begin
          state <= ST_CMD;
        end
      end else if (cs_rise) begin
        state   <= ST_IDLE;
        io_oe_o <= 4'h0;
        if (state == ST_BOOT && boot_byte_done) boot_armed_o <= 1'b0; // R09 R11
        if (state == ST_IN && bit_cnt == data_len(cmd_reg)) begin // R17 R19 R21
          if (cmd_reg == `SFSBC_CMD_WLSET && !op_active) begin
            write_enable_latch_o <= 1'b1; // R23
          end else if (cmd_reg == `SFSBC_CMD_CLR) begin
            erase_err_o <= 1'b0; // R01 R02 R03
            prog_err_o  <= 1'b0; // R01
          end else if (write_enable_latch_o && !wip_now) begin // R25
            if (cmd_reg == `SFSBC_CMD_CFGWR) begin
              op_active <= 1'b1; // R16 R17
              op_is_cfg <= 1'b1;
              op_cnt    <= NV_OP_CYCLES[15:0];
              pend_cfg  <= byte_swap(in_shift); // R16
            end else if (cmd_reg == `SFSBC_CMD_PATNV) begin
              op_active <= 1'b1; // R19
              op_is_cfg <= 1'b0;
              op_cnt    <= NV_OP_CYCLES[15:0];
              pend_pat  <= in_shift[7:0];
            end else if (cmd_reg == `SFSBC_CMD_PATV) begin
              learning_pattern_o <= in_shift[7:0]; // R21
            end
          end
        end
      end else if (sck_rise) begin
        if (state == ST_CMD) begin
          cmd_reg <= next_cmd;
          bit_cnt <= bit_cnt + 6'h01;
          if (bit_cnt == 6'h07) begin
            bit_cnt <= 6'h00;
            rep     <= 4'h0;
            if (next_cmd == `SFSBC_CMD_CORRD) begin
              state   <= ST_ADDR; // R04
              out_sel <= SEL_ECC;
            end else if (next_cmd == `SFSBC_CMD_CFGRD) begin
              state   <= ST_OUT; // R14 R15
              out_sel <= SEL_CFG;
            end else if (next_cmd == `SFSBC_CMD_PATRD) begin
              state   <= ST_OUT; // R22
              out_sel <= SEL_PAT;
            end else if (next_cmd == `SFSBC_CMD_WLSET || next_cmd == `SFSBC_CMD_CLR ||
                         next_cmd == `SFSBC_CMD_CFGWR || next_cmd == `SFSBC_CMD_PATNV ||
                         next_cmd == `SFSBC_CMD_PATV) begin
              state <= ST_IN;
            end else begin
              state <= ST_IDLE;
            end
          end
        end else if (state == ST_ADDR) begin
          in_shift <= {in_shift[30:0], si_s};
          bit_cnt  <= bit_cnt + 6'h01;
          if (bit_cnt == 6'h1f) begin
            ecc_addr_o <= {in_shift[30:0], si_s} & `SFSBC_ECC_MASK; // R04
            state      <= ST_DUMMY;
            wait_cnt   <= `SFSBC_ECC_DUMMY + 8'h01; // R04
          end
        end else if (state == ST_IN) begin
          in_shift <= {in_shift[30:0], si_s};
          if (bit_cnt != 6'h3f) bit_cnt <= bit_cnt + 6'h01;
        end else if (state == ST_BOOT && out_left == 4'h1) begin
          boot_byte_done <= 1'b1; // R09
        end
      end
      if (sck_fall && (state == ST_DUMMY || state == ST_BOOT) && wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
        if (state == ST_DUMMY && wait_cnt == 8'h01) state <= ST_OUT;
      end
      if (do_load) begin
        out_byte <= load_byte;
        rep      <= rep + 4'h1;
        if (load_quad) begin
          out_left <= 4'h2; // R12
          io_o     <= load_byte[7:4];
          io_oe_o  <= 4'hf;
        end else begin
          out_left <= 4'h8;
          io_o     <= {2'h0, load_byte[7], 1'b0};
          io_oe_o  <= 4'h2;
        end
        if (state == ST_BOOT || boot_start) begin
          array_addr_o <= array_addr_o + 32'h0000_0001; // R09
        end else if (out_sel == SEL_ECC && rep == 4'hf) begin
          ecc_addr_o <= ecc_addr_o + `SFSBC_ECC_STEP; // R05
        end
      end else if (do_shift) begin
        out_left <= out_left - 4'h1;
        if (cur_quad) begin
          out_byte <= {out_byte[3:0], 4'h0};
          io_o     <= out_byte[3:0];
        end else begin
          out_byte <= {out_byte[6:0], 1'b0};
          io_o     <= {2'h0, out_byte[6], 1'b0};
        end
      end
      if (op_done) begin
        op_active            <= 1'b0;
        write_enable_latch_o <= 1'b0; // R17 R20
        if (op_is_cfg && erase_fail_i) erase_err_o <= 1'b1; // R18
        else if (prog_fail_i) prog_err_o <= 1'b1; // R18 R20
      end
    end
  end
endmodule // sfsbc_core

// [logic/sfsbc_defs.vh]
`ifndef SFSBC_DEFS_VH
`define SFSBC_DEFS_VH
// Operation
// R01: command 30h clears erase and program failure flags, no latch needed
// R02: flag clearing is accepted while write in progress reads one
// R03: flag clearing leaves the write enable latch unchanged
// R04: 18h takes a 32-bit unit address, low four bits zero, then eight dummies
// R05: unit status byte is sent sixteen times, then next unit, until deselect
// R06: with boot enabled, a read from start address is armed at reset
// R07: boot output waits the 8-bit delay count; host sends nothing meanwhile
// R08: boot starts at 23-bit start field times 512, default address zero
// R09: boot streams while selected; deselect after a byte returns to commands
// R10: host clocks at least one whole boot byte before deselecting
// R11: boot streaming does not restart until the next power cycle or reset
// R12: quad enable set sends boot data four bits per cycle, else single
// R13: host limits boot clock to 50, 133 or 104 MHz by delay and quad
// R14: 14h shifts boot register out, low byte first, msb first per byte
// R15: boot register read repeats while the host keeps clocking
// R16: 15h needs the latch set, then 32 bits low byte first msb first
// R17: deselect right after bit 32, else dropped; timed update, busy, latch cleared
// R18: update erase failure sets erase flag, program failure sets program flag; code sets only the erase flag when both fail
// R19: 43h needs latch, one byte, deselect after bit 8, then timed busy operation
// R20: failed pattern program sets program flag; completion clears the latch
// R21: 4Ah needs latch, one byte, deselect after bit 8, applied at once
// R22: 41h shifts the 8-bit learning pattern out, repeated per eight cycles
// R23: command 06h sets the write enable latch gating write commands
// R24: learning pattern is offered for double data rate read dummy cycles
// R25: write commands with the latch clear are ignored without side effects
// R26: boot start, delay and enable are non-volatile and reloaded at reset
`define SFSBC_CMD_WLSET     8'h06
`define SFSBC_CMD_CLR       8'h30
`define SFSBC_CMD_CORRD     8'h18
`define SFSBC_CMD_CFGRD     8'h14
`define SFSBC_CMD_CFGWR     8'h15
`define SFSBC_CMD_PATNV     8'h43
`define SFSBC_CMD_PATV      8'h4a
`define SFSBC_CMD_PATRD     8'h41
`define SFSBC_BEN_BIT       0
`define SFSBC_DLY_LSB       1
`define SFSBC_DLY_MSB       8
`define SFSBC_SA_LSB        9
`define SFSBC_SA_MSB        31
`define SFSBC_BOOT_CFG_RST  32'h0000_0000
`define SFSBC_PATTERN_RST   8'h00
`define SFSBC_ECC_DUMMY     8'h08
`define SFSBC_ECC_MASK      32'hffff_fff0
`define SFSBC_ECC_STEP      32'h0000_0010
`define SFSBC_CLK_NS        8
`define SFSBC_NV_OP_NS      2000
`define SFSBC_NV_OP_CYC     ((`SFSBC_NV_OP_NS + `SFSBC_CLK_NS - 1) / `SFSBC_CLK_NS)
`endif

// [logic/sfsbc_sync.v]
`timescale 1ns/100ps
module sfsbc_sync #(
  parameter             WIDTH   = 3,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input  wire             sys_clk_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta;
  // two stage synchroniser, reset to the pin idle levels
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta   <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // sfsbc_sync

// [test/sfsbc_chk.sv]
`timescale 1ns/100ps
module sfsbc_chk (
  input wire        sys_clk_i,
  input wire        rst_b_i,
  input wire        cs_b_i,
  input wire        quad_enable_i,
  input wire [3:0]  io_oe_o,
  input wire [31:0] ecc_addr_o,
  input wire [31:0] array_addr_o,
  input wire [31:0] boot_stream_config_o,
  input wire [7:0]  learning_pattern_o,
  input wire [7:0]  pattern_nonvolatile_reg_o,
  input wire        write_enable_latch_o,
  input wire        write_in_progress_o,
  input wire        erase_err_o,
  input wire        prog_err_o,
  input wire        boot_armed_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_busy; (erase_err_o || prog_err_o) |=> write_in_progress_o; endproperty
  a_busy: assert property (p_busy) else $error("flag set but not busy");
  property p_unit; ecc_addr_o[3:0] == 4'h0; endproperty
  a_unit: assert property (p_unit) else $error("unit address unaligned");
  property p_start; $rose(rst_b_i) |=> array_addr_o == {boot_stream_config_o[31:9], 9'h000}; endproperty
  a_start: assert property (p_start) else $error("boot address wrong");
  property p_arm; $rose(rst_b_i) |=> boot_armed_o == boot_stream_config_o[0]; endproperty
  a_arm: assert property (p_arm) else $error("boot arm wrong");
  property p_wel; $rose(write_enable_latch_o) |-> cs_b_i; endproperty
  a_wel: assert property (p_wel) else $error("latch set while selected");
  property p_pat; !$stable(learning_pattern_o) |-> cs_b_i; endproperty
  a_pat: assert property (p_pat) else $error("pattern changed while selected");
  property p_cfg; !$stable(boot_stream_config_o) |-> write_in_progress_o; endproperty
  a_cfg: assert property (p_cfg) else $error("boot config changed while idle");
  property p_nv; !$stable(pattern_nonvolatile_reg_o) |-> write_in_progress_o; endproperty
  a_nv: assert property (p_nv) else $error("nv pattern changed while idle");
  property p_idle; cs_b_i [*5] |-> io_oe_o == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("driving while deselected");
  property p_quad; io_oe_o == 4'hf |-> quad_enable_i; endproperty
  a_quad: assert property (p_quad) else $error("quad drive without quad bit");
  c_boot: cover property ($fell(boot_armed_o));
  c_quad: cover property (io_oe_o == 4'hf);
  c_perr: cover property ($rose(prog_err_o));
  c_unit: cover property (!$stable(ecc_addr_o) && !cs_b_i);
endmodule // sfsbc_chk

// [test/sfsbc_host.sv]
`timescale 1ns/100ps
module sfsbc_host (
  output reg        cs_b_o,
  output reg        sck_o,
  output reg        mosi_o,
  input  wire [3:0] line_i
);
  reg [3:0] rxq [$];
  integer   k;
  initial begin
    cs_b_o = 1'b1;
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end
  // mode 0 frame, tx msb first, rx after tx bits
  task xfer(input [63:0] tx, input integer ntx, input integer nrx, input q);
    begin
      cs_b_o = 1'b0;
      for (k = 0; k < ntx + nrx; k = k + 1) begin
        if (k < ntx)
          mosi_o = tx[ntx-1-k];
        #62.5;
        sck_o = 1'b1;
        if (k >= ntx)
          rxq.push_back(q ? line_i : {3'b000, line_i[1]});
        #62.5;
        sck_o = 1'b0;
      end
      #62.5;
      cs_b_o = 1'b1;
      mosi_o = ~mosi_o;
      #100;
    end
  endtask
endmodule // sfsbc_host

// [test/test_spi_flash_status_boot_cmds.sv]
`timescale 1ns/100ps
module test_spi_flash_status_boot_cmds;
  reg         sys_clk_i, rst_b_i, pwr_on_b_i, quad_enable_i, erase_fail_i, prog_fail_i, tg;
  wire        cs_b_i, sck_i, mosi;
  wire [3:0]  io_i, io_o, io_oe_o;
  wire [7:0]  ecc_status_i, array_data_i, learning_pattern_o, pattern_nonvolatile_reg_o;
  wire [31:0] ecc_addr_o, array_addr_o, boot_stream_config_o;
  wire        write_enable_latch_o, write_in_progress_o, erase_err_o, prog_err_o, boot_armed_o;
  integer     miscompares, total_checks, seed, d, k;
  reg [31:0]  m_cfg, v, a, b0;
  reg [7:0]   m_pat, m_nv, p;
  reg         m_wel, m_ee, m_pe;
  reg [3:0]   exq [$];
  function [7:0] arr_f(input [31:0] x);
    arr_f = x[7:0] ^ x[16:9];
  endfunction
  function [31:0] swap(input [31:0] x);
    swap = {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  assign io_i = (io_oe_o & io_o) | (~io_oe_o & {{3{tg}}, mosi});
  assign ecc_status_i = ecc_addr_o[11:4] ^ 8'ha5;
  assign array_data_i = arr_f(array_addr_o);
  sfsbc_core #(.NV_OP_CYCLES(4)) i_dut (.sys_clk_i, .rst_b_i, .pwr_on_b_i, .cs_b_i, .sck_i,
    .io_i, .io_o, .io_oe_o, .quad_enable_i, .ecc_status_i, .array_data_i, .erase_fail_i,
    .prog_fail_i, .ecc_addr_o, .array_addr_o, .boot_stream_config_o, .learning_pattern_o,
    .pattern_nonvolatile_reg_o, .write_enable_latch_o, .write_in_progress_o, .erase_err_o,
    .prog_err_o, .boot_armed_o);
  sfsbc_host i_host (.cs_b_o(cs_b_i), .sck_o(sck_i), .mosi_o(mosi), .line_i(io_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) tg <= ~tg;
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cmp_q;
    begin
      cmp(i_host.rxq.size(), exq.size());
      while (exq.size() > 0 && i_host.rxq.size() > 0)
        cmp(i_host.rxq.pop_front(), exq.pop_front());
      exq.delete();
      i_host.rxq.delete();
    end
  endtask
  task put_b(input [7:0] b, input q);
    integer i;
    begin
      if (q) begin
        exq.push_back(b[7:4]);
        exq.push_back(b[3:0]);
      end else
        for (i = 7; i >= 0; i = i - 1)
          exq.push_back({3'b000, b[i]});
    end
  endtask
  task chk_st;
    begin
      cmp(boot_stream_config_o, m_cfg);
      cmp(pattern_nonvolatile_reg_o, m_nv);
      cmp(learning_pattern_o, m_pat);
      cmp(write_enable_latch_o, m_wel);
      cmp(erase_err_o, m_ee);
      cmp(prog_err_o, m_pe);
      cmp(write_in_progress_o, m_ee | m_pe);
    end
  endtask
  task cmd(input [63:0] tx, input integer ntx, input integer nrx, input q);
    integer w;
    begin
      @(negedge sys_clk_i);
      i_host.xfer(tx, ntx, nrx, q);
      @(negedge sys_clk_i);
      for (w = 0; w < 100 && write_in_progress_o === 1'b1 && !(erase_err_o | prog_err_o); w++)
        @(negedge sys_clk_i);
      if (w == 100) begin
        miscompares = miscompares + 1;
        wrap_up;
      end
    end
  endtask
  task rst_pulse;
    begin
      @(negedge sys_clk_i);
      rst_b_i = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      m_pat = m_nv;
      m_wel = 1'b0;
      repeat (4) @(negedge sys_clk_i);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #400000;
    miscompares = miscompares + 1;
    wrap_up;
  end
  initial begin
    {seed, miscompares, total_checks} = {32'd25, 64'd0};
    {tg, rst_b_i, pwr_on_b_i, quad_enable_i, erase_fail_i, prog_fail_i} = 6'h00;
    {m_cfg, m_nv, m_pat, m_wel, m_ee, m_pe} = 51'h0;
    repeat (16) @(negedge sys_clk_i);
    {rst_b_i, pwr_on_b_i} = 2'h3;
    repeat (4) @(negedge sys_clk_i);
    chk_st;
    d = 1 + {$random(seed)} % 4;
    v = $random(seed);
    v[8:0] = {d[7:0], 1'b1};
    p = $random(seed);
    b0 = {v[31:9], 9'h000};
    cmd({8'h15, swap(v)}, 40, 0, 0);
    chk_st;
    cmd(8'h06, 8, 0, 0);
    m_wel = 1'b1;
    chk_st;
    cmd({8'h15, swap(v)} >> 1, 39, 0, 0);
    chk_st;
    cmd({8'h15, swap(v)}, 40, 0, 0);
    {m_cfg, m_wel} = {v, 1'b0};
    chk_st;
    cmd(8'h14, 8, 64, 0);
    for (k = 0; k < 8; k = k + 1) put_b(v[8*(k%4) +: 8], 0);
    cmp_q;
    cmd(8'h06, 8, 0, 0);
    cmd({8'h4a, p}, 16, 0, 0);
    {m_wel, m_pat} = {1'b1, p};
    chk_st;
    cmd(8'h41, 8, 16, 0);
    put_b(p, 0);
    put_b(p, 0);
    cmp_q;
    prog_fail_i = 1'b1;
    cmd({8'h43, ~p}, 16, 0, 0);
    prog_fail_i = 1'b0;
    {m_pe, m_wel} = 2'b10;
    chk_st;
    cmd(8'h06, 8, 0, 0);
    cmd(8'h30, 8, 0, 0);
    {m_pe, m_wel} = 2'b01;
    chk_st;
    erase_fail_i = 1'b1;
    cmd({8'h15, swap(~v)}, 40, 0, 0);
    erase_fail_i = 1'b0;
    {m_ee, m_wel} = 2'b10;
    chk_st;
    cmd(8'h30, 8, 0, 0);
    cmd(8'h06, 8, 0, 0);
    cmd({8'h43, ~p}, 16, 0, 0);
    {m_ee, m_nv} = {1'b0, ~p};
    chk_st;
    a = $random(seed) & 32'hffff_fff0;
    cmd({8'h18, a, 8'h00}, 48, 136, 0);
    for (k = 0; k < 17; k = k + 1) put_b(ecc_status_f(a + (k / 16) * 16), 0);
    cmp_q;
    rst_pulse;
    cmp(boot_armed_o, 1'b1);
    cmp(array_addr_o, b0);
    cmd(64'h0, d, 4, 0);
    i_host.rxq.delete();
    cmp(boot_armed_o, 1'b1);
    rst_pulse;
    cmd(64'h0, d, 24, 0);
    for (k = 0; k < 3; k = k + 1) put_b(arr_f(b0 + k), 0);
    cmp_q;
    cmp(boot_armed_o, 1'b0);
    cmd(8'h41, 8, 8, 0);
    put_b(m_pat, 0);
    cmp_q;
    quad_enable_i = 1'b1;
    rst_pulse;
    cmd(64'h0, d, 6, 1);
    for (k = 0; k < 3; k = k + 1) put_b(arr_f(b0 + k), 1);
    cmp_q;
    cmd(8'h06, 8, 0, 0);
    v[8:1] = 8'h00;
    cmd({8'h15, swap(v)}, 40, 0, 0);
    m_cfg = v;
    rst_pulse;
    cmd(64'h0, 0, 4, 1);
    for (k = 0; k < 2; k = k + 1) put_b(arr_f(b0 + k), 1);
    cmp_q;
    chk_st;
    wrap_up;
  end
  function [7:0] ecc_status_f(input [31:0] x);
    ecc_status_f = x[11:4] ^ 8'ha5;
  endfunction
endmodule // test_spi_flash_status_boot_cmds
bind sfsbc_core sfsbc_chk i_chk (.sys_clk_i, .rst_b_i, .cs_b_i, .quad_enable_i, .io_oe_o,
  .ecc_addr_o, .array_addr_o, .boot_stream_config_o, .learning_pattern_o,
  .pattern_nonvolatile_reg_o, .write_enable_latch_o, .write_in_progress_o, .erase_err_o,
  .prog_err_o, .boot_armed_o);
